// [include/scp_pkg.sv]
package scp_pkg;
    // Register byte offsets on APB
    localparam logic [11:0] OFF_DIVIDE_CONTROL = 12'h000;
    localparam logic [11:0] OFF_RC_TRIM        = 12'h004;
    localparam logic [11:0] OFF_ASYNC_TIMER    = 12'h008;
    localparam logic [11:0] OFF_STATUS         = 12'h00c;

    // Divide control fields
    localparam int          CHANGE_ENABLE_BIT  = 7;
    localparam int          SELECT_MSB         = 3;
    localparam logic [3:0]  SELECT_MAX_CODE    = 4'h8;
    localparam logic [3:0]  SELECT_RESET_PLAIN = 4'h0;
    localparam logic [3:0]  SELECT_RESET_DIV8  = 4'h3;
    localparam logic [2:0]  CHANGE_WINDOW      = 3'h4;

    // Trim fields
    localparam int          TRIM_RANGE_BIT     = 7;

    // Async timer register field
    localparam int          EXT_INPUT_BIT      = 0;

    // Clock source and start-up time fuse codes
    localparam logic [3:0]  SOURCE_EXTERNAL    = 4'h0;
    localparam logic [1:0]  SUT_RESERVED       = 2'h3;

    // Start-up timing
    localparam int          CLK_HZ             = 50_000_000;
    localparam int          WAKE_CK            = 6;
    localparam int          RESET_CK           = 14;
    localparam int          DELAY_SHORT_US     = 4100;
    localparam int          DELAY_LONG_US      = 65000;
    localparam int          DELAY_SHORT_CYC    = (DELAY_SHORT_US * (CLK_HZ / 1_000_000));
    localparam int          DELAY_LONG_CYC     = (DELAY_LONG_US * (CLK_HZ / 1_000_000));

    typedef struct packed {
        logic [3:0] source_select_fuses;
        logic [1:0] startup_time_fuses;
        logic       clock_output_fuse;
        logic       initial_divide_by_eight_fuse;
    } scp_fuses_t;

    typedef struct packed {
        logic io_domain_clock;
        logic converter_domain_clock;
        logic core_domain_clock;
        logic program_memory_domain_clock;
    } scp_domains_t;
endpackage

// [verilog/scp_clock_control.sv]
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
module scp_clock_control #(
    parameter logic [7:0] FACTORY_TRIM    = 8'h80,
    parameter int         DELAY_SHORT_CYC = scp_pkg::DELAY_SHORT_CYC,
    parameter int         DELAY_LONG_CYC  = scp_pkg::DELAY_LONG_CYC
) (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire scp_pkg::scp_fuses_t  fuses,
    input  wire logic                 main_osc_input_pin,
    input  wire logic                 rc_osc_clock,
    input  wire logic                 wake_request,
    output logic                      source_clock,
    output scp_pkg::scp_domains_t     domains,
    output logic                      clock_output_pin,
    output logic                      clock_output_oe,
    output logic                      startup_done,
    output logic                      timer_osc_enable,
    output logic                      timer_osc_external_select,
    output logic [7:0]                rc_oscillator_trim
);
    initial begin
        if (DELAY_SHORT_CYC < 1 || DELAY_LONG_CYC < DELAY_SHORT_CYC) begin
            $error("Start-up delay counts out of range");
        end
    end

    typedef enum logic [1:0] {
        SCP_ST_RESET_CK = 2'b00,
        SCP_ST_DELAY    = 2'b01,
        SCP_ST_RUN      = 2'b10,
        SCP_ST_WAKE     = 2'b11
    } scp_state_t;

    logic             ext_s1_r;
    logic             ext_s2_r;
    logic             ext_s3_r;
    logic             ext_level_r;
    logic             ext_rise;
    logic             external_sel;
    logic             src_tick;
    logic [7:0]       ripple_r;
    logic [3:0]       select_r;
    logic [3:0]       active_sel_r;
    logic [3:0]       pending_sel_r;
    logic             pending_r;
    logic [1:0]       edge_cnt_r;
    logic             change_en_r;
    logic [2:0]       window_r;
    logic [7:0]       trim_r;
    logic             ext_input_r;
    logic             sys_clk_r;
    logic             div_tick;
    scp_state_t       state_r;
    logic [31:0]      delay_r;
    logic [31:0]      delay_target;
    logic             fuses_taken_r;
    logic             wr_en;
    logic             rd_en;
    logic             addr_ok;
    logic             wr_ctrl;

    // Three-stage synchroniser; only stages two and three are compared
    always_ff @(posedge clk) begin
        ext_s1_r <= main_osc_input_pin;
        ext_s2_r <= ext_s1_r;
        ext_s3_r <= ext_s2_r;
        if (reset) begin
            ext_level_r <= 1'b0;
        end else if (ext_s2_r == ext_s3_r) begin
            ext_level_r <= ext_s3_r;
        end
    end

    assign external_sel = (fuses.source_select_fuses == scp_pkg::SOURCE_EXTERNAL);
    assign ext_rise     = (ext_s2_r == ext_s3_r) && ext_s3_r && !ext_level_r;
    // RC oscillator is modelled as a tick enable on clk
    assign src_tick     = external_sel ? ext_rise : rc_osc_clock;

    // Timer oscillator shares the main pins, so it needs the RC source
    assign timer_osc_enable          = !external_sel;
    assign timer_osc_external_select = ext_input_r && !external_sel;

    // Ripple counter runs on every source tick
    always_ff @(posedge clk) begin
        if (reset) begin
            ripple_r <= 8'h00;
        end else if (src_tick) begin
            ripple_r <= ripple_r + 8'h01;
        end
    end

    // Divided tick: counter bits below the active select are all ones
    always_comb begin
        div_tick = src_tick;
        for (int i = 0; i < 8; i++) begin
            if (i < int'(active_sel_r) && !ripple_r[i]) begin
                div_tick = 1'b0;
            end
        end
    end

    // Output clock toggles on divided ticks; runs during start-up, low only in reset
    always_ff @(posedge clk) begin
        if (reset) begin
            sys_clk_r <= 1'b0;
        end else if (div_tick) begin
            sys_clk_r <= ~sys_clk_r;
        end
    end

    // Switch after two edges at the old rate boundary, keeping pulses whole
    always_ff @(posedge clk) begin
        if (reset) begin
            active_sel_r <= SELECT_RESET_VALUE();
            pending_r    <= 1'b0;
            edge_cnt_r   <= 2'h0;
        end else if (!fuses_taken_r) begin
            // Fuse taken on the first cycle after reset; that one cycle still runs at divide-by-one
            active_sel_r <= fuses.initial_divide_by_eight_fuse ? scp_pkg::SELECT_RESET_DIV8
                                                               : scp_pkg::SELECT_RESET_PLAIN;
        end else if (pending_r) begin
            if (div_tick && sys_clk_r) begin
                if (edge_cnt_r == 2'h1) begin
                    active_sel_r <= select_r;
                    pending_r    <= 1'b0;
                    edge_cnt_r   <= 2'h0;
                end else begin
                    edge_cnt_r <= edge_cnt_r + 2'h1;
                end
            end
        end else if (active_sel_r != select_r) begin
            pending_r  <= 1'b1;
            edge_cnt_r <= 2'h0;
        end
    end

    function automatic logic [3:0] SELECT_RESET_VALUE();
        return scp_pkg::SELECT_RESET_PLAIN;
    endfunction

    always_comb begin
        domains.io_domain_clock             = sys_clk_r;
        domains.converter_domain_clock      = sys_clk_r;
        domains.core_domain_clock           = sys_clk_r;
        domains.program_memory_domain_clock = sys_clk_r;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            source_clock <= 1'b0;
        end else begin
            source_clock <= ext_level_r;
        end
    end

    // Output buffer stays live through reset; the fuse is a static level
    always_ff @(posedge clk) begin
        // Divided clock goes out even while start-up is pending
        clock_output_pin <= sys_clk_r;
        clock_output_oe  <= fuses.clock_output_fuse;
    end

    // Fuse strap caught on the first clocked cycle after release
    always_ff @(posedge clk) begin
        if (reset) begin
            fuses_taken_r <= 1'b0;
        end else if (!fuses_taken_r) begin
            fuses_taken_r <= 1'b1;
        end
    end

    // Start-up: reset adds 14 CK plus fuse delay, wake adds 6 CK
    always_comb begin
        case (fuses.startup_time_fuses)
            2'h1:    delay_target = 32'(DELAY_SHORT_CYC);
            2'h2:    delay_target = 32'(DELAY_LONG_CYC);
            default: delay_target = 32'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= SCP_ST_RESET_CK;
            delay_r <= 32'h0;
        end else begin
            case (state_r)
                SCP_ST_RESET_CK: begin
                    if (src_tick) begin
                        if (delay_r >= 32'(scp_pkg::RESET_CK - 1)) begin
                            state_r <= SCP_ST_DELAY;
                            delay_r <= 32'h0;
                        end else begin
                            delay_r <= delay_r + 32'h1;
                        end
                    end
                end
                SCP_ST_DELAY: begin
                    if (delay_r >= delay_target
                        && fuses.startup_time_fuses != scp_pkg::SUT_RESERVED) begin
                        state_r <= SCP_ST_RUN;
                        delay_r <= 32'h0;
                    end else if (delay_r < delay_target) begin
                        delay_r <= delay_r + 32'h1;
                    end
                end
                SCP_ST_RUN: begin
                    if (wake_request) begin
                        state_r <= SCP_ST_WAKE;
                        delay_r <= 32'h0;
                    end
                end
                SCP_ST_WAKE: begin
                    if (src_tick) begin
                        if (delay_r >= 32'(scp_pkg::WAKE_CK - 1)) begin
                            state_r <= SCP_ST_RUN;
                            delay_r <= 32'h0;
                        end else begin
                            delay_r <= delay_r + 32'h1;
                        end
                    end
                end
                default: begin
                    state_r <= SCP_ST_RESET_CK;
                    delay_r <= 32'h0;
                end
            endcase
        end
    end

    assign startup_done = (state_r == SCP_ST_RUN);

    // APB slave, zero wait states; read data loads in setup so it stands at access
    assign addr_ok = (paddr == scp_pkg::OFF_DIVIDE_CONTROL) || (paddr == scp_pkg::OFF_RC_TRIM)
                   || (paddr == scp_pkg::OFF_ASYNC_TIMER) || (paddr == scp_pkg::OFF_STATUS);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign rd_en   = psel && !penable && !pwrite;
    assign wr_ctrl = wr_en && (paddr == scp_pkg::OFF_DIVIDE_CONTROL);

    // Change enable arms only on a write with every other bit of the low byte zero
    always_ff @(posedge clk) begin
        if (reset) begin
            change_en_r <= 1'b0;
            window_r    <= 3'h0;
        end else if (wr_ctrl && change_en_r && !pwdata[scp_pkg::CHANGE_ENABLE_BIT]) begin
            change_en_r <= 1'b0;
            window_r    <= 3'h0;
        end else if (change_en_r) begin
            // Rewrite of the enable does not restart the window
            if (window_r >= scp_pkg::CHANGE_WINDOW - 3'h1) begin
                change_en_r <= 1'b0;
                window_r    <= 3'h0;
            end else begin
                window_r <= window_r + 3'h1;
            end
        end else if (wr_ctrl && pwdata[7:0] == 8'h80) begin
            change_en_r <= 1'b1;
            window_r    <= 3'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            select_r <= scp_pkg::SELECT_RESET_PLAIN;
        end else if (!fuses_taken_r) begin
            select_r <= fuses.initial_divide_by_eight_fuse ? scp_pkg::SELECT_RESET_DIV8
                                                           : scp_pkg::SELECT_RESET_PLAIN;
        end else if (wr_ctrl && change_en_r && !pwdata[scp_pkg::CHANGE_ENABLE_BIT]) begin
            // Reserved codes keep the previous factor
            if (pwdata[scp_pkg::SELECT_MSB:0] <= scp_pkg::SELECT_MAX_CODE) begin
                select_r <= pwdata[scp_pkg::SELECT_MSB:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            trim_r      <= FACTORY_TRIM;
            ext_input_r <= 1'b0;
        end else if (wr_en && paddr == scp_pkg::OFF_RC_TRIM) begin
            trim_r <= pwdata[7:0];
        end else if (wr_en && paddr == scp_pkg::OFF_ASYNC_TIMER) begin
            ext_input_r <= pwdata[scp_pkg::EXT_INPUT_BIT];
        end
    end

    // Bit 7 range, bits 6..0 fine; passed to the analog oscillator as is
    assign rc_oscillator_trim = trim_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            prdata <= 32'h0;
        end else if (rd_en) begin
            case (paddr)
                scp_pkg::OFF_DIVIDE_CONTROL: prdata <= {24'h0, change_en_r, 3'h0, select_r};
                scp_pkg::OFF_RC_TRIM:        prdata <= {24'h0, trim_r};
                scp_pkg::OFF_ASYNC_TIMER:    prdata <= {31'h0, ext_input_r};
                scp_pkg::OFF_STATUS:         prdata <= {24'h0, active_sel_r, pending_r,
                                                        startup_done, timer_osc_enable,
                                                        external_sel};
                default:                     prdata <= 32'h0;
            endcase
        end
    end
endmodule

// [tb/scp_ext_clock_src.sv]
`timescale 1ns/10ps
module scp_ext_clock_src #(
    parameter int HALF = 2
) (
    input  wire logic clk,
    input  wire logic run,
    output logic      pin
);
    int cnt = 0;
    initial pin = 1'b0;
    // Fixed period, so no cycle-to-cycle jump is ever offered
    always_ff @(posedge clk) begin
        if (!run) begin
            cnt <= 0;
            pin <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            pin <= ~pin;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// [tb/scp_clock_control_checker.sv]
`timescale 1ns/10ps
module scp_clock_control_checker #(
    parameter logic [7:0] FACTORY_TRIM = 8'h80
) (
    input wire logic                  clk,
    input wire logic                  reset,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [11:0]           paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire scp_pkg::scp_fuses_t   fuses,
    input wire logic                  main_osc_input_pin,
    input wire logic                  rc_osc_clock,
    input wire logic                  wake_request,
    input wire logic                  source_clock,
    input wire scp_pkg::scp_domains_t domains,
    input wire logic                  clock_output_pin,
    input wire logic                  clock_output_oe,
    input wire logic                  startup_done,
    input wire logic                  timer_osc_enable,
    input wire logic                  timer_osc_external_select,
    input wire logic [7:0]            rc_oscillator_trim
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence early_hold;
        !startup_done [*8];
    endsequence
    oe_follows_fuse_a: assert property (!$past(reset) |->
        clock_output_oe == $past(fuses.clock_output_fuse)) else $error("clock output enable off");
    oe_in_reset_a: assert property (disable iff (1'b0) $past(reset) && reset |->
        clock_output_oe == $past(fuses.clock_output_fuse)) else $error("clock output off in reset");
    clkout_divided_a: assert property (clock_output_oe |->
        clock_output_pin == domains.io_domain_clock
        || clock_output_pin == $past(domains.io_domain_clock)) else $error("clock output differs");
    domains_together_a: assert property (domains.io_domain_clock == domains.core_domain_clock
        && domains.converter_domain_clock == domains.program_memory_domain_clock
        && domains.io_domain_clock == domains.converter_domain_clock) else $error("domains split");
    apb_ready_a: assert property (psel && penable |-> pready) else $error("no ready");
    timer_osc_gate_a: assert property (timer_osc_enable ==
        (fuses.source_select_fuses != scp_pkg::SOURCE_EXTERNAL)) else $error("timer osc enable");
    ext_input_gate_a: assert property (timer_osc_external_select |->
        timer_osc_enable) else $error("timer ext input with external source");
    trim_reset_a: assert property ($fell(reset) |->
        rc_oscillator_trim == FACTORY_TRIM) else $error("trim reset value");
    startup_hold_a: assert property ($fell(reset)
        && fuses.source_select_fuses == scp_pkg::SOURCE_EXTERNAL |-> early_hold)
        else $error("start-up too short");
    reserved_stall_a: assert property (fuses.startup_time_fuses == scp_pkg::SUT_RESERVED
        && fuses.source_select_fuses == scp_pkg::SOURCE_EXTERNAL |-> !startup_done)
        else $error("reserved start-up code ran");
endmodule
bind scp_clock_control scp_clock_control_checker #(.FACTORY_TRIM(FACTORY_TRIM)) chk_u (
    .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .fuses, .main_osc_input_pin, .rc_osc_clock, .wake_request, .source_clock, .domains,
    .clock_output_pin, .clock_output_oe, .startup_done, .timer_osc_enable,
    .timer_osc_external_select, .rc_oscillator_trim);

// [tb/tb_system_clock_prescale_select.sv]
`timescale 1ns/10ps
module tb_system_clock_prescale_select;
    logic                  clk = 1'b0;
    logic                  reset = 1'b1;
    logic                  psel = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite = 1'b0;
    logic [11:0]           paddr = 12'h000;
    logic [31:0]           pwdata = 32'h0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    scp_pkg::scp_fuses_t   fuses = {4'h2, 2'h0, 1'b1, 1'b1};
    logic                  main_osc_input_pin;
    logic                  rc_osc_clock = 1'b1;
    logic                  wake_request = 1'b0;
    logic                  run_src = 1'b0;
    logic                  source_clock;
    scp_pkg::scp_domains_t domains;
    logic                  clock_output_pin;
    logic                  clock_output_oe;
    logic                  startup_done;
    logic                  timer_osc_enable;
    logic                  timer_osc_external_select;
    logic [7:0]            rc_oscillator_trim;
    logic [31:0]           q;
    logic                  e;
    logic                  prev_src;
    int                    err_total = 0;
    int                    n_compared = 0;
    int                    i;
    int                    n;
    // Written value beside the select it should leave active
    logic [11:0]           rows [9] = '{12'h088, 12'h000, 12'h011, 12'h022, 12'h044,
                                        12'h055, 12'h066, 12'h077, 12'h033};

    scp_clock_control #(.DELAY_SHORT_CYC(20), .DELAY_LONG_CYC(40)) dut_u (
        .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .fuses, .main_osc_input_pin, .rc_osc_clock, .wake_request, .source_clock, .domains,
        .clock_output_pin, .clock_output_oe, .startup_done, .timer_osc_enable,
        .timer_osc_external_select, .rc_oscillator_trim);
    scp_ext_clock_src #(.HALF(2)) src_u (.clk(clk), .run(run_src), .pin(main_osc_input_pin));

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic timeout;
        err_total++;
        print_verdict();
    endtask

    // Read data stands in the access cycle and is taken at the access edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) timeout();
        e = pslverr;
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic change(input logic [7:0] d);
        apb(1'b1, scp_pkg::OFF_DIVIDE_CONTROL, 8'h80);
        apb(1'b1, scp_pkg::OFF_DIVIDE_CONTROL, d);
    endtask

    task automatic wait_sel(input logic [3:0] exp);
        int k;
        k = 0;
        do begin
            apb(1'b0, scp_pkg::OFF_STATUS, 8'h00);
            k++;
        end while (q[7:4] !== exp && k < 600);
        if (k >= 600) timeout();
        chk({28'h0, q[7:4]}, {28'h0, exp});
    endtask

    // Long enough for a wrong switch at divide-by-32 to show
    task automatic keep_sel(input logic [3:0] exp);
        repeat (300) @(posedge clk);
        apb(1'b0, scp_pkg::OFF_STATUS, 8'h00);
        chk({28'h0, q[7:4]}, {28'h0, exp});
    endtask

    task automatic wait_done(input logic lvl, input int bound);
        n = 0;
        while (startup_done !== lvl && n < bound) begin
            @(posedge clk);
            n++;
        end
        if (n >= bound) timeout();
    endtask

    task automatic do_reset(input scp_pkg::scp_fuses_t f);
        reset <= 1'b1;
        fuses <= f;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
    endtask

    initial begin
        do_reset({4'h2, 2'h0, 1'b1, 1'b1});
        apb(1'b0, scp_pkg::OFF_STATUS, 8'h00);
        chk({28'h0, q[7:4]}, 32'h3);
        apb(1'b0, scp_pkg::OFF_RC_TRIM, 8'h00);
        chk(q, 32'h80);
        chk({31'h0, clock_output_oe}, 32'h1);
        chk({31'h0, timer_osc_enable}, 32'h1);
        $display("reset test done");
        for (i = 0; i < 9; i++) begin
            change(rows[i][11:4]);
            wait_sel(rows[i][3:0]);
        end
        $display("select table test done");
        for (i = 9; i < 16; i++) begin
            change(i[7:0]);
            keep_sel(4'h3);
        end
        apb(1'b1, scp_pkg::OFF_DIVIDE_CONTROL, 8'h05);
        keep_sel(4'h3);
        apb(1'b1, scp_pkg::OFF_DIVIDE_CONTROL, 8'h81);
        apb(1'b1, scp_pkg::OFF_DIVIDE_CONTROL, 8'h05);
        keep_sel(4'h3);
        change(8'h85);
        keep_sel(4'h3);
        apb(1'b1, scp_pkg::OFF_DIVIDE_CONTROL, 8'h80);
        change(8'h05);
        keep_sel(4'h3);
        change(8'h05);
        apb(1'b1, scp_pkg::OFF_DIVIDE_CONTROL, 8'h06);
        keep_sel(4'h5);
        $display("change sequence test done");
        apb(1'b1, scp_pkg::OFF_RC_TRIM, 8'h7f);
        apb(1'b0, scp_pkg::OFF_RC_TRIM, 8'h00);
        chk(q, 32'h7f);
        chk({24'h0, rc_oscillator_trim}, 32'h7f);
        apb(1'b1, scp_pkg::OFF_ASYNC_TIMER, 8'h01);
        chk({31'h0, timer_osc_external_select}, 32'h1);
        apb(1'b0, 12'h010, 8'h00);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        $display("register test done");
        run_src <= 1'b1;
        do_reset({scp_pkg::SOURCE_EXTERNAL, 2'h1, 1'b0, 1'b0});
        wait_done(1'b1, 3000);
        chk({31'h0, n >= (scp_pkg::RESET_CK - 1) * 4 + 20}, 32'h1);
        apb(1'b0, scp_pkg::OFF_STATUS, 8'h00);
        chk({28'h0, q[7:4]}, 32'h0);
        chk({31'h0, q[0]}, 32'h1);
        // Pin period is four clocks, so forty clocks hold ten rises
        n = 0;
        prev_src = source_clock;
        repeat (40) begin
            @(posedge clk);
            if (source_clock && !prev_src) n++;
            prev_src = source_clock;
        end
        chk(n, 32'ha);
        apb(1'b1, scp_pkg::OFF_ASYNC_TIMER, 8'h01);
        chk({30'h0, timer_osc_enable, timer_osc_external_select}, 32'h0);
        wake_request <= 1'b1;
        @(posedge clk);
        wake_request <= 1'b0;
        wait_done(1'b0, 20);
        wait_done(1'b1, 400);
        chk({31'h0, n >= (scp_pkg::WAKE_CK - 1) * 4}, 32'h1);
        $display("external clock test done");
        do_reset({scp_pkg::SOURCE_EXTERNAL, scp_pkg::SUT_RESERVED, 1'b0, 1'b0});
        repeat (300) @(posedge clk);
        chk({31'h0, startup_done}, 32'h0);
        $display("reserved start-up test done");
        print_verdict();
    end
endmodule
